// file: sbfm_pkg.sv
/*
  Package for the side-band force-enable mask block: register offsets,
  field layout, reset values and the carrier structs.
  Assumes nothing of its surroundings beyond a SystemVerilog compiler.
*/
`default_nettype none

package sbfm_pkg;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam logic [7:0] SBFM_OFFSET_OUTPUTS_8_15 = 8'h09;
  localparam logic [7:0] SBFM_OFFSET_OUTPUTS_16_19 = 8'h0a;
  localparam logic [7:0] SBFM_RESET_OUTPUTS_8_15 = 8'h00;
  localparam logic [3:0] SBFM_RESET_OUTPUTS_16_19 = 4'h0;
  localparam logic [3:0] SBFM_RESERVED_READ = 4'h0;

  // ********************************************************************
  // Field layout
  // ********************************************************************
  localparam int SBFM_FIRST_OUTPUT_LOW = 8;
  localparam int SBFM_FIRST_OUTPUT_HIGH = 16;
  localparam int SBFM_LOW_BITS = 8;
  localparam int SBFM_HIGH_BITS = 4;
  localparam int SBFM_OUTPUTS = 12;

  // One register access from the SMBus engine.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbfm_access_t;

  // Read answer back to the SMBus engine.
  typedef struct packed {
    logic hit;
    logic [7:0] rdata;
  } sbfm_answer_t;

endpackage

`default_nettype wire

// file: sbfm_enable_cell.sv
/*
  One output's enable combiner: in side-band mode the side-band enable ORed with its mask bit, otherwise on,
  registered so that the output enable changes only on a clock edge.
  Assumes the side-band enable arrives already synchronised to clk.
*/
`default_nettype none

module sbfm_enable_cell
  import sbfm_pkg::*;
(
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Inputs.
  input wire logic sideband_mode,
  input wire logic sideband_en,
  input wire logic mask_bit,
  // Output.
  output logic enable_out
);

  // ********************************************************************
  // Registered combine
  // ********************************************************************
  // Registering avoids a combinational glitch when mask and side-band
  // enable change in the same cycle.
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_out <= 1'b0;
    end else if (clk_en) begin
      if (sideband_mode) begin
        enable_out <= sideband_en | mask_bit;
      end else begin
        enable_out <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// file: sbfm_mask_regs.sv
/*
  Side-band force-enable masks for clock outputs 8 to 19: two SMBus
  registers and the per-output effective enables they steer.
  Assumes an SMBus engine on clk presents one access per cycle, and that
  side-band enables for outputs 8 to 19 come from a shift register on clk.
  The side-band enable pin is asynchronous and is synchronised here.
*/
`default_nettype none

module sbfm_mask_regs
  import sbfm_pkg::*;
#(
  parameter int OUTPUTS = SBFM_OUTPUTS
) (
  // Clock, reset and enable.
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // SMBus register access.
  input wire sbfm_access_t access,
  output sbfm_answer_t answer,
  // Side-band inputs.
  input wire logic sideband_enable_pin,
  input wire logic [OUTPUTS-1:0] sideband_out_en,
  // Effective enables for outputs 8 to 19, bit 0 is output 8.
  output logic [OUTPUTS-1:0] clock_output_n_en,
  // Mask contents seen as outputs, bit 0 is output 8.
  output logic [OUTPUTS-1:0] force_mask
);

  // ********************************************************************
  // Elaboration check
  // ********************************************************************
  if (OUTPUTS != SBFM_LOW_BITS + SBFM_HIGH_BITS) begin : g_bad
    $error("OUTPUTS must equal the twelve mapped mask bits.");
  end

  // ********************************************************************
  // Pin synchroniser
  // ********************************************************************
  logic sb_meta_reg;
  logic sb_sync_reg;

  // Two flops on the asynchronous pin; only the second is read.
  always_ff @(posedge clk) begin
    if (reset) begin
      sb_meta_reg <= 1'b0;
      sb_sync_reg <= 1'b0;
    end else if (clk_en) begin
      sb_meta_reg <= sideband_enable_pin;
      sb_sync_reg <= sb_meta_reg;
    end
  end

  // ********************************************************************
  // Mask registers
  // ********************************************************************
  logic [7:0] mask_low_reg;
  logic [3:0] mask_high_reg;

  // Host writes land here; the upper nibble at Ah has no storage.
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_low_reg <= SBFM_RESET_OUTPUTS_8_15;
      mask_high_reg <= SBFM_RESET_OUTPUTS_16_19;
    end else if (clk_en && access.wr) begin
      if (access.addr == SBFM_OFFSET_OUTPUTS_8_15) begin
        mask_low_reg <= access.wdata;
      end
      if (access.addr == SBFM_OFFSET_OUTPUTS_16_19) begin
        mask_high_reg <= access.wdata[3:0];
      end
    end
  end

  // ********************************************************************
  // Read path
  // ********************************************************************
  // Reads answer one cycle later; unmapped offsets answer with hit low
  // and zero data so the SMBus engine can NACK them.
  always_ff @(posedge clk) begin
    if (reset) begin
      answer <= '0;
    end else if (clk_en) begin
      answer <= '0;
      if (access.rd) begin
        if (access.addr == SBFM_OFFSET_OUTPUTS_8_15) begin
          answer.hit <= 1'b1;
          answer.rdata <= mask_low_reg;
        end else if (access.addr == SBFM_OFFSET_OUTPUTS_16_19) begin
          answer.hit <= 1'b1;
          answer.rdata <= {SBFM_RESERVED_READ, mask_high_reg};
        end
      end
    end
  end

  // Bit 0 of the vector is output 8; output 19 sits at the top.
  logic [OUTPUTS-1:0] mask_vec;
  assign mask_vec = {mask_high_reg, mask_low_reg};

  always_ff @(posedge clk) begin
    if (reset) begin
      force_mask <= '0;
    end else if (clk_en) begin
      force_mask <= mask_vec;
    end
  end

  // ********************************************************************
  // Per-output enable combine
  // ********************************************************************
  // The side-band pin high selects side-band mode; low hands output
  // control to SMBus and the enable pins, modelled here as enabled.
  for (genvar i = 0; i < OUTPUTS; i++) begin : g_out
    sbfm_enable_cell u_cell (
      .clk(clk),
      .reset(reset),
      .clk_en(clk_en),
      .sideband_mode(sb_sync_reg),
      .sideband_en(sideband_out_en[i]),
      .mask_bit(mask_vec[i]),
      .enable_out(clock_output_n_en[i])
    );
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  // Tied to the read itself, so a frozen answer cannot trip it.
  a_reserved_zero : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && access.rd && access.addr == SBFM_OFFSET_OUTPUTS_16_19)
    |=> answer.hit && answer.rdata[7:4] == SBFM_RESERVED_READ)
    else $error("Reserved mask bits read nonzero.");

  a_force_enable : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && sb_sync_reg && mask_vec[0]) |=> clock_output_n_en[0])
    else $error("Forced output 8 not enabled.");

  a_sideband_defer : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && sb_sync_reg && !mask_vec[11] && !sideband_out_en[11])
    |=> !clock_output_n_en[11])
    else $error("Output 19 enabled without cause.");

  a_low_write : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && access.wr && access.addr == SBFM_OFFSET_OUTPUTS_8_15)
    |=> mask_low_reg == $past(access.wdata))
    else $error("Mask 9h write lost.");

  a_high_write : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && access.wr && access.addr == SBFM_OFFSET_OUTPUTS_16_19)
    |=> mask_high_reg == $past(access.wdata[3:0]))
    else $error("Mask Ah write lost.");

  // A read with no write in the same cycle returns the contents held before it.
  a_read_low : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && access.rd && access.addr == SBFM_OFFSET_OUTPUTS_8_15
     && !access.wr) |=> answer.hit && answer.rdata == $past(mask_low_reg))
    else $error("Mask 9h read wrong.");

  a_read_high : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && access.rd && access.addr == SBFM_OFFSET_OUTPUTS_16_19)
    |=> answer.rdata == {4'h0, $past(mask_high_reg)})
    else $error("Mask Ah read wrong.");

  a_unmapped_read : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && access.rd && access.addr != SBFM_OFFSET_OUTPUTS_8_15 &&
     access.addr != SBFM_OFFSET_OUTPUTS_16_19) |=> !answer.hit)
    else $error("Unmapped read answered.");

  // Every forced output is on, whatever its side-band enable says.
  a_force_all : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && sb_sync_reg) |=>
      (clock_output_n_en & $past(mask_vec)) == $past(mask_vec))
    else $error("A forced output was left off.");

  // In side-band mode each enable is exactly side-band OR mask.
  a_enable_combine : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && sb_sync_reg) |=>
      clock_output_n_en == ($past(sideband_out_en) | $past(mask_vec)))
    else $error("Effective enable differs from side-band OR mask.");

  // Outside side-band mode the masks have no effect at all.
  a_mode_off : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && !sb_sync_reg) |=> clock_output_n_en == '1)
    else $error("Output off outside side-band mode.");

  // The mask copy output trails the registers by exactly one cycle.
  a_mask_copy : assert property (@(posedge clk)
    disable iff (reset)
    clk_en |=> force_mask == $past(mask_vec))
    else $error("Mask copy output out of step.");

  // A read answer stands for one enabled cycle only, so a stale hit cannot
  // be mistaken for the answer to a later access.
  a_answer_once : assert property (@(posedge clk)
    disable iff (reset)
    (clk_en && !access.rd) |=> !answer.hit && answer.rdata == 8'h00)
    else $error("Read answer held past its cycle.");

  // A low clock enable freezes both masks, host writes included.
  a_freeze_masks : assert property (@(posedge clk)
    disable iff (reset)
    !clk_en |=> $stable(mask_low_reg) && $stable(mask_high_reg))
    else $error("Mask changed while clock enable was low.");

  // Reset clears masks, answer and enables by the following edge.
  a_reset_clear : assert property (@(posedge clk)
    reset |=> mask_low_reg == SBFM_RESET_OUTPUTS_8_15 &&
      mask_high_reg == SBFM_RESET_OUTPUTS_16_19 &&
      !answer.hit && clock_output_n_en == '0)
    else $error("Reset left state behind.");

endmodule

`default_nettype wire

// file: sbfm_host_model.sv
/*
  Management host model: issues single register accesses to the masks.
  Assumes the bench calls xfer and the answer lands one cycle later.
*/
`default_nettype none

module sbfm_host_model
  import sbfm_pkg::*;
(
  // Clock.
  input wire logic clk,
  // Register access.
  output sbfm_access_t access,
  input wire sbfm_answer_t answer
);
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************************************************
  // Access task
  // ********************************************************************
  initial access = '0;

  // Held across one rising edge; idle fields carry the inverse so that a
  // stale address or data can never pass for a live one.
  task automatic xfer(input logic wr, input logic [7:0] a,
      input logic [7:0] d, output sbfm_answer_t ans);
    @(negedge clk);
    access <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(negedge clk);
    ans = answer;
    access <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
endmodule

`default_nettype wire

// file: sbfm_mask_regs_tb_top.sv
/*
  Self-checking bench for the force-enable masks of outputs 8 to 19.
  Assumes the host model drives the access port; all else is driven here.
*/
`default_nettype none

module sbfm_mask_regs_tb_top
  import sbfm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ********************************************************************
  // Signals and instances
  // ********************************************************************
  logic clk, reset, clk_en, pin;
  logic [11:0] sb_en, en_out, fmask;
  sbfm_access_t access;
  sbfm_answer_t answer, ans;
  int bad_count, checks_done;
  logic [31:0] seed;
  logic [7:0] lo, hi;
  logic [11:0] exp;

  sbfm_mask_regs uut (.clk(clk), .reset(reset), .clk_en(clk_en),
    .access(access), .answer(answer), .sideband_enable_pin(pin),
    .sideband_out_en(sb_en), .clock_output_n_en(en_out),
    .force_mask(fmask));
  sbfm_host_model host (.clk(clk), .access(access), .answer(answer));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction

  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Outside side-band mode the enable is simply on.
  task automatic settle();
    repeat (4) @(negedge clk);
    chk("mask", {hi[3:0], lo}, fmask);
    chk("enables", pin ? (sb_en | {hi[3:0], lo}) : 12'hfff, en_out);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, ans);
    if (a == 8'h09) lo = d;
    if (a == 8'h0a) hi = {4'h0, d[3:0]};
  endtask

  task automatic rd_chk(input logic [7:0] a);
    host.xfer(1'b0, a, 8'h00, ans);
    chk("hit", 12'(a == 8'h09 || a == 8'h0a), 12'(ans.hit));
    chk("rdata", a == 8'h09 ? 12'(lo) : a == 8'h0a ? 12'(hi) : 12'h0,
      12'(ans.rdata));
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    pin = 1'b0;
    sb_en = '0;
    bad_count = 0;
    checks_done = 0;
    seed = 32'hfe9f741f;
    lo = '0;
    hi = '0;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    rd_chk(8'h09);
    rd_chk(8'h0a);
    pin = 1'b1;
    // Walking one through each mask register in turn, every side-band enable off.
    for (int i = 0; i < 12; i++) begin
      wr(i < 8 ? 8'h09 : 8'h0a, 8'h01 << (i % 8));
      settle();
    end
    wr(8'h0a, 8'hf0);
    rd_chk(8'h0a);
    // Random traffic, unmapped offsets and mode changes mixed in.
    repeat (40) begin
      seed = xs(seed);
      pin = seed[3];
      sb_en = seed[31:20];
      wr(seed[1:0] == 2'b00 ? seed[15:8] : seed[2] ? 8'h09 : 8'h0a,
        seed[23:16]);
      rd_chk(seed[4] ? 8'h09 : seed[15:8]);
      rd_chk(8'h0a);
      settle();
    end
    // A low clock enable freezes masks and enables, writes included.
    exp = pin ? (sb_en | {hi[3:0], lo}) : 12'hfff;
    clk_en = 1'b0;
    sb_en = ~sb_en;
    host.xfer(1'b1, 8'h09, ~lo, ans);
    repeat (2) @(negedge clk);
    chk("frozen", exp, en_out);
    clk_en = 1'b1;
    rd_chk(8'h09);
    settle();
    // A second reset clears both masks and every output.
    reset = 1'b1;
    @(negedge clk);
    chk("reset_en", 12'h000, en_out);
    chk("reset_mask", 12'h000, fmask);
    chk("reset_hit", 12'h000, 12'(answer.hit));
    reset = 1'b0;
    lo = '0;
    hi = '0;
    settle();
    tally_and_finish();
  end
endmodule

`default_nettype wire
